// ### common/cpusup_params.svh
// Constants for the processor supervisor and RAM enable gate
`ifndef CPUSUP_PARAMS_SVH
`define CPUSUP_PARAMS_SVH

// ==================================================
// Timing
`define CPUSUP_CLK_HZ 50000000
`define CPUSUP_HOLD_MS 250
`define CPUSUP_HOLD_CYC ((`CPUSUP_CLK_HZ / 1000) * `CPUSUP_HOLD_MS)
`define CPUSUP_DEBOUNCE_US 10
`define CPUSUP_DEBOUNCE_CYC ((`CPUSUP_CLK_HZ / 1000000) * `CPUSUP_DEBOUNCE_US)
`define CPUSUP_WDOG_MS 1600
`define CPUSUP_WDOG_CYC ((`CPUSUP_CLK_HZ / 1000) * `CPUSUP_WDOG_MS)
`define CPUSUP_CNT_W 32

`endif

// ### common/cpusup_pkg.sv
// Types for the processor supervisor
package cpusup_pkg;

    // ==================================================
    // Reset sequencer states
    typedef enum logic [1:0] {
        CPUSUP_RUN,
        CPUSUP_FAIL,
        CPUSUP_HOLD
    } cpusup_state_t;

endpackage : cpusup_pkg

// ### hdl/cpusup_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module cpusup_sync
#(
    parameter logic RESET_VAL = 1'b1
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Asynchronous level in, clean level out
    input wire logic async_i,
    output logic sync_o
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_sync;

    // ==================================================
    // Stage one is read by stage two only
    always_comb
    begin
        next_sync = sync_o;
        if (stage2 == stage3)
        begin
            next_sync = stage3;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
            sync_o <= RESET_VAL;
        end
        else
        begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_o <= next_sync;
        end
    end

endmodule : cpusup_sync

// ### hdl/cpusup_top.sv
// Processor supervisor: reset sequencer, watchdog and SRAM byte enables
// Summary of operation
// (RL1) Reset output is asserted while the power-fail indication is active.
// (RL2) Reset stays asserted 250 ms after power-fail clears.
// (RL3) Pushbutton input is debounced; a valid press gives at least 250 ms reset.
// (RL4) Watchdog asserts reset when timeout passes without a low strobe.
// (RL5) Controller drives RAM enable low to use RAM; high blocks every chip enable.
// (RL6) Active-low chip enable for the low SRAM byte.
// (RL7) Active-low chip enable for the high SRAM byte.
// (RL8) High enable asserted only while upper enable and RAM enable are low.
// (RL9) Low enable asserted only while lower enable and RAM enable are low.
// (RL10) Reset pin is open-drain and doubles as pushbutton input, stretched 250 ms.
// (RL11) Each low strobe restarts the watchdog; timeout is a parameter.
`timescale 1ns/1ps
`include "cpusup_params.svh"

module cpusup_top
import cpusup_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `CPUSUP_HOLD_CYC,
    parameter int unsigned DEBOUNCE_CYC = `CPUSUP_DEBOUNCE_CYC,
    parameter int unsigned WDOG_CYC = `CPUSUP_WDOG_CYC
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Supply monitor
    input wire logic power_fail_i,
    // Processor reset pin, open drain
    input wire logic cpu_reset_n_i,
    output logic cpu_reset_n_o,
    output logic cpu_reset_oe_o,
    // Watchdog strobe
    input wire logic watchdog_kick_n_i,
    // SRAM enable gate
    input wire logic ram_enable_in_n_i,
    input wire logic upper_byte_enable_n_i,
    input wire logic lower_byte_enable_n_i,
    output logic high_byte_select_out_n_o,
    output logic low_byte_select_out_n_o
);

    // ==================================================
    // Input synchronisers
    logic pfail_s;
    logic pin_s;
    logic kick_s;
    logic ram_en_s;
    logic ube_s;
    logic lbe_s;

    cpusup_sync #(.RESET_VAL(1'b1)) u_sync_pfail (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .async_i(power_fail_i), .sync_o(pfail_s));
    cpusup_sync #(.RESET_VAL(1'b1)) u_sync_pin (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .async_i(cpu_reset_n_i), .sync_o(pin_s));
    cpusup_sync #(.RESET_VAL(1'b1)) u_sync_kick (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .async_i(watchdog_kick_n_i), .sync_o(kick_s));
    cpusup_sync #(.RESET_VAL(1'b1)) u_sync_ram (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .async_i(ram_enable_in_n_i), .sync_o(ram_en_s));
    cpusup_sync #(.RESET_VAL(1'b1)) u_sync_ube (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .async_i(upper_byte_enable_n_i), .sync_o(ube_s));
    cpusup_sync #(.RESET_VAL(1'b1)) u_sync_lbe (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .async_i(lower_byte_enable_n_i), .sync_o(lbe_s));

    // ==================================================
    // Pushbutton debounce
    // Our own drive pulls the pin low, so presses are only seen while released
    logic [`CPUSUP_CNT_W-1:0] deb_cnt;
    logic [`CPUSUP_CNT_W-1:0] next_deb_cnt;
    logic press;

    always_comb
    begin
        next_deb_cnt = '0;
        press = 1'b0;
        if (!pin_s && !cpu_reset_oe_o)
        begin
            next_deb_cnt = deb_cnt + `CPUSUP_CNT_W'(1);
            if (deb_cnt >= `CPUSUP_CNT_W'(DEBOUNCE_CYC - 1))
            begin
                press = 1'b1; // [RL3] [RL10]
                next_deb_cnt = deb_cnt;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            deb_cnt <= '0;
        end
        else
        begin
            deb_cnt <= next_deb_cnt;
        end
    end

    // ==================================================
    // Watchdog
    logic [`CPUSUP_CNT_W-1:0] wd_cnt;
    logic [`CPUSUP_CNT_W-1:0] next_wd_cnt;
    logic wd_expire;

    // ==================================================
    // Reset sequencer
    cpusup_state_t state;
    cpusup_state_t next_state;
    logic [`CPUSUP_CNT_W-1:0] hold_cnt;
    logic [`CPUSUP_CNT_W-1:0] next_hold_cnt;
    logic next_rst_oe;

    always_comb
    begin
        next_wd_cnt = wd_cnt + `CPUSUP_CNT_W'(1);
        wd_expire = 1'b0;
        if (!kick_s || state != CPUSUP_RUN)
        begin
            next_wd_cnt = '0; // [RL11]
        end
        else if (wd_cnt >= `CPUSUP_CNT_W'(WDOG_CYC - 1))
        begin
            wd_expire = 1'b1; // [RL4]
            next_wd_cnt = '0;
        end
    end

    always_comb
    begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        unique case (state)
            CPUSUP_RUN:
            begin
                if (pfail_s)
                begin
                    next_state = CPUSUP_FAIL; // [RL1]
                end
                else if (press || wd_expire)
                begin
                    next_state = CPUSUP_HOLD; // [RL3] [RL4]
                    next_hold_cnt = '0;
                end
            end
            CPUSUP_FAIL:
            begin
                next_hold_cnt = '0;
                if (!pfail_s)
                begin
                    next_state = CPUSUP_HOLD; // [RL2]
                end
            end
            CPUSUP_HOLD:
            begin
                next_hold_cnt = hold_cnt + `CPUSUP_CNT_W'(1);
                if (pfail_s)
                begin
                    next_state = CPUSUP_FAIL; // [RL1]
                end
                else if (hold_cnt >= `CPUSUP_CNT_W'(HOLD_CYC - 1))
                begin
                    next_state = CPUSUP_RUN; // [RL2] [RL3]
                end
            end
            default:
            begin
                next_state = CPUSUP_FAIL;
            end
        endcase
        next_rst_oe = (next_state != CPUSUP_RUN); // [RL1] [RL10]
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state <= CPUSUP_FAIL;
            hold_cnt <= '0;
            wd_cnt <= '0;
            cpu_reset_oe_o <= 1'b1;
            cpu_reset_n_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            wd_cnt <= next_wd_cnt;
            cpu_reset_oe_o <= next_rst_oe; // [RL10]
            cpu_reset_n_o <= 1'b0;
        end
    end

    // ==================================================
    // SRAM chip enable gate
    logic next_high_sel_n;
    logic next_low_sel_n;

    always_comb
    begin
        next_high_sel_n = ube_s | ram_en_s; // [RL5] [RL7] [RL8]
        next_low_sel_n = lbe_s | ram_en_s; // [RL5] [RL6] [RL9]
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            high_byte_select_out_n_o <= 1'b1;
            low_byte_select_out_n_o <= 1'b1;
        end
        else
        begin
            high_byte_select_out_n_o <= next_high_sel_n;
            low_byte_select_out_n_o <= next_low_sel_n;
        end
    end

    // ==================================================
    // Checks
    chk_fail_drives_reset: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL1]
        (state == CPUSUP_FAIL) |=> cpu_reset_oe_o)
        else $error("reset not driven during power fail");

    chk_hold_length: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL2]
        (state == CPUSUP_HOLD && hold_cnt < `CPUSUP_CNT_W'(HOLD_CYC - 1) && !pfail_s)
        |=> state == CPUSUP_HOLD)
        else $error("reset hold ended early");

    chk_hold_release: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL2]
        (state == CPUSUP_HOLD && hold_cnt == `CPUSUP_CNT_W'(HOLD_CYC - 1) && !pfail_s)
        |=> state == CPUSUP_RUN && !cpu_reset_oe_o)
        else $error("reset hold not released");

    chk_press_reset: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL3]
        (state == CPUSUP_RUN && press && !pfail_s) |=> state == CPUSUP_HOLD && hold_cnt == '0)
        else $error("press did not start reset");

    chk_wdog_timeout: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL4]
        (state == CPUSUP_RUN && wd_expire && !pfail_s) |=> cpu_reset_oe_o)
        else $error("watchdog expiry missed");

    chk_kick_restart: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL11]
        !kick_s |=> wd_cnt == '0)
        else $error("strobe did not restart watchdog");

    chk_high_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL8]
        !high_byte_select_out_n_o |-> !$past(ube_s) && !$past(ram_en_s))
        else $error("high enable without both inputs low");

    chk_low_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL9]
        !low_byte_select_out_n_o |-> !$past(lbe_s) && !$past(ram_en_s))
        else $error("low enable without both inputs low");

    chk_pin_low: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL10]
        !cpu_reset_n_o)
        else $error("open drain output driven high");

    cov_power_cycle: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        state == CPUSUP_FAIL ##1 state == CPUSUP_HOLD);
    cov_press: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        state == CPUSUP_RUN && press);
    cov_wdog: cover property (@(posedge sys_clk_i) disable iff (srst_i) wd_expire);
    cov_fail_in_hold: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        state == CPUSUP_HOLD ##1 state == CPUSUP_FAIL);
    cov_both_bytes: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        !high_byte_select_out_n_o && !low_byte_select_out_n_o);

endmodule : cpusup_top

// ### dv/cpusup_board_model.sv
// Board-side model: reset pin pull-up, pushbutton and processor strobe
`timescale 1ns/1ps

module cpusup_board_model
#(
    parameter int unsigned KICK_PERIOD = 20
)
(
    // Clock
    input wire logic sys_clk_i,
    // Reset pin
    input wire logic pin_drive_n_i,
    input wire logic pin_oe_i,
    input wire logic button_i,
    output logic pin_n_o,
    // Watchdog strobe
    input wire logic kick_en_i,
    output logic watchdog_kick_n_o
);
    int unsigned cnt = 0;
    // ==========================================
    // Pin
    // Pull-up wins only when neither device nor button pulls low
    assign pin_n_o = (pin_oe_i ? pin_drive_n_i : 1'b1) & ~button_i;
    // ==========================================
    // Strobe
    // Low for 4 cycles so the synchroniser stages agree on it
    always @(negedge sys_clk_i)
    begin
        cnt <= kick_en_i ? (cnt + 1) % KICK_PERIOD : 0;
        watchdog_kick_n_o <= !(kick_en_i && cnt < 4);
    end
endmodule : cpusup_board_model

// ### dv/tb.sv
// Self-checking bench for the processor supervisor
`timescale 1ns/1ps

module tb;
    localparam int unsigned HOLD = 50;
    localparam int unsigned DEB = 8;
    localparam int unsigned WDOG = 100;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic power_fail_i = 1'b0;
    logic button = 1'b0;
    logic kick_en = 1'b1;
    logic ram_n = 1'b1;
    logic ube_n = 1'b1;
    logic lbe_n = 1'b1;
    logic [31:0] rng = 32'h00005bc5;
    wire logic pin_n;
    wire logic kick_n;
    wire logic drv_n;
    wire logic oe;
    wire logic hi_n;
    wire logic lo_n;
    int fail_count = 0;
    int n_tests = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    cpusup_top #(.HOLD_CYC(HOLD), .DEBOUNCE_CYC(DEB), .WDOG_CYC(WDOG)) u_cpusup_top (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .power_fail_i(power_fail_i),
        .cpu_reset_n_i(pin_n), .cpu_reset_n_o(drv_n), .cpu_reset_oe_o(oe),
        .watchdog_kick_n_i(kick_n), .ram_enable_in_n_i(ram_n),
        .upper_byte_enable_n_i(ube_n), .lower_byte_enable_n_i(lbe_n),
        .high_byte_select_out_n_o(hi_n), .low_byte_select_out_n_o(lo_n));

    cpusup_board_model u_cpusup_board_model (
        .sys_clk_i(sys_clk_i), .pin_drive_n_i(drv_n), .pin_oe_i(oe),
        .button_i(button), .pin_n_o(pin_n), .kick_en_i(kick_en),
        .watchdog_kick_n_o(kick_n));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift

    // A chip enable may only go low while RAM enable and its byte enable are both low
    function automatic logic exp_select(input logic ram_en_n, input logic byte_en_n);
        return ram_en_n | byte_en_n;
    endfunction : exp_select

    task automatic cyc(input int unsigned n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc

    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask : check

    // Bounded wait on the reset drive; running out ends the run
    task automatic wait_oe(input logic val, input int unsigned bound);
        for (int i = 0; i < bound && oe !== val; i++)
            cyc(1);
        check("reset drive wait", oe, val);
        if (oe !== val)
            give_verdict();
    endtask : wait_oe

    initial
    begin
        cyc(10);
        srst_i = 1'b0;
        cyc(HOLD - 10);
        check("power-up hold", oe, 1'b1);
        wait_oe(1'b0, 40);
        $display("Test power-up done");
        // Corner patterns first: disabled with both bytes asked, then all enabled
        for (int k = 0; k < 24; k++)
        begin
            rng = xorshift(rng);
            {lbe_n, ube_n, ram_n} = (k == 0) ? 3'b001 : (k == 1) ? 3'b000 : rng[2:0];
            cyc(8);
            check("high select", hi_n, exp_select(ram_n, ube_n));
            check("low select", lo_n, exp_select(ram_n, lbe_n));
        end
        $display("Test sram gate done");
        power_fail_i = 1'b1;
        cyc(8);
        check("fail assert", oe, 1'b1);
        cyc(20 + rng[4:0]);
        check("fail stands", oe, 1'b1);
        power_fail_i = 1'b0;
        cyc(20);
        // A new fail in mid-hold must start the hold over
        power_fail_i = 1'b1;
        cyc(8);
        check("fail in hold", oe, 1'b1);
        power_fail_i = 1'b0;
        cyc(HOLD);
        check("fail hold", oe, 1'b1);
        wait_oe(1'b0, 20);
        $display("Test power fail done");
        // Let the pin's own release leave the synchroniser before the bounce
        cyc(10);
        // A bounce shorter than the debounce time must be ignored
        button = 1'b1;
        cyc(3);
        button = 1'b0;
        cyc(20);
        check("bounce ignored", oe, 1'b0);
        button = 1'b1;
        cyc(DEB + 10);
        button = 1'b0;
        check("press detect", oe, 1'b1);
        check("pin drive", drv_n, 1'b0);
        cyc(HOLD - 20);
        check("press stretch", oe, 1'b1);
        wait_oe(1'b0, 40);
        $display("Test pushbutton done");
        cyc(3 * WDOG);
        check("kicked watchdog", oe, 1'b0);
        kick_en = 1'b0;
        cyc(60);
        check("watchdog early", oe, 1'b0);
        wait_oe(1'b1, 60);
        kick_en = 1'b1;
        wait_oe(1'b0, HOLD + 10);
        $display("Test watchdog done");
        srst_i = 1'b1;
        cyc(4);
        check("reset drive", oe, 1'b1);
        check("reset select", lo_n, 1'b1);
        check("reset select high", hi_n, 1'b1);
        srst_i = 1'b0;
        wait_oe(1'b0, HOLD + 20);
        $display("Test second reset done");
        give_verdict();
    end
endmodule : tb
